//--- hw/drs_ref_select.sv
// Reference monitors, source selection and mode control for two timing paths.
// Assumes references, sync and strap inputs are synchronous to CLK.
// Functional notes
// - Free-run frequency follows oscillator plus software trim
// - Locked mode locks to most suitable reference
// - Holdover keeps last good reference frequency
// - Loop arithmetic uses 54-bit resolution
// - Monitor mode: frequency+activity, activity, or off
// - Monitors run continuously on all inputs
// - Hard limit rejects, soft limit only flags
// - Auto select picks highest priority valid input
// - Each path has its own priorities
// - Auto or host-forced source per path
// - Per-input activity alarm threshold
// - Automatic free-run, locked, holdover switching
// - Primary bandwidth 10 steps, auxiliary three
// - Extra features only on primary path
// - Primary mode forceable; auxiliary only reference forceable
// - Auxiliary measures phase between two inputs
// - Primary loop always generates 77.76 MHz word
// - Auxiliary follows primary 8 kHz when configured
// - Sync pulse resets 8 kHz divider, and 2 kHz divider only at 2 kHz sync rate
// - 2, 4 or 8 kHz sync accepted
// - Pre-divider brings 8 kHz multiples down
// - Rate strap presets rate bit at reset
// - Fast detector flags loss, freezes holdover
module drs_ref_select
	import drs_pkg::*;
#(
	parameter int ACT_CYC  = ACT_TIMEOUT_CYC,
	parameter int LEAK_CYCS = LEAK_CYC
)(
	// Clock, reset, enable
	input  wire logic            CLK,
	input  wire logic            RSTN,
	input  wire logic            CE,
	// Avalon-MM slave
	input  wire logic [7:0]      AVS_ADDRESS,
	input  wire logic            AVS_READ,
	input  wire logic            AVS_WRITE,
	input  wire logic [31:0]     AVS_WRITEDATA,
	input  wire logic [3:0]      AVS_BYTEENABLE,
	output logic      [31:0]     AVS_READDATA,
	output logic                 AVS_WAITREQUEST,
	// Reference, sync and strap pins
	input  wire logic [NREF-1:0] REF_INPUT,
	input  wire logic            SYNC_PULSE_INPUT,
	input  wire logic            RATE_SEL,
	// Timing outputs
	output logic                 PRI_CLK_OUT,
	output logic                 AUX_CLK_OUT,
	output logic                 FRAME_8K_OUT,
	output logic                 MFRAME_2K_OUT,
	output logic      [1:0]      PRI_MODE,
	output logic      [1:0]      AUX_MODE,
	output logic                 REF_LOST
);
	localparam logic [19:0] FRAME20 = 20'(FRAME_CYC);
	localparam logic [NCO_W-1:0] NOM = NCO_W'(NCO_NOM64);

	logic [31:0] ctrl, bwreg, cal, hold_ofs, mon, pprio, aprio, thr, divn, lim;
	logic [NREF-1:0] ref_q, rise, tick, act_alarm, soft_flag, hard_flag, fast_lost, valid, ok;
	logic [19:0] since [NREF];
	logic [19:0] per_last [NREF];
	logic [17:0] act_cnt [NREF];
	logic [7:0] bucket [NREF];
	logic [13:0] divc [NREF];
	logic [19:0] leak_cnt;
	logic leak;
	drs_state_t pri_state, aux_state;
	logic [1:0] pri_sel, aux_sel;
	logic [2:0] pri_cand, aux_cand;
	logic [NCO_W-1:0] pri_freq, hold_freq, aux_freq, pri_acc, aux_acc, free_word;
	logic pri_carry, frame_tick, sync_q, sync_rise;
	logic [13:0] frame_cnt;
	logic [1:0] mf_cnt;
	logic [19:0] aux_since;
	logic aux_src_tick, aux_src_ok;
	logic [19:0] phase_cnt, phase_res;
	logic phase_run;
	wire wr = CE && AVS_WRITE && !AVS_WAITREQUEST;
	wire [1:0] pri_force = ctrl[C_PMODE+:2];
	wire nonrev = ctrl[C_NONREV];
	wire pforce = ctrl[C_PFORCE];
	wire aforce = ctrl[C_AFORCE];
	wire aux_follow = ctrl[C_FOLLOW];
	wire hold_man = ctrl[C_HMAN];

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[8*b+:8] = wd[8*b+:8];
		return r;
	endfunction

	// Lowest nonzero priority number wins; zero disables the input
	function automatic logic [2:0] best_ref(input logic [NREF-1:0] okv, input logic [15:0] prio);
		logic [2:0] r;
		logic [3:0] p, bp;
		r = 3'h0;
		bp = 4'hf;
		for (int i = 0; i < NREF; i++)
		begin
			p = prio[4*i+:4];
			if (okv[i] && p != 4'h0 && (!r[2] || p < bp))
			begin
				r = {1'b1, 2'(i)};
				bp = p;
			end
		end
		return r;
	endfunction

	// Error in cycles of a measured 8 kHz period, sign-extended to loop width
	function automatic logic [NCO_W-1:0] perr(input logic [19:0] per);
		logic [20:0] e;
		e = {1'b0, per} - {1'b0, FRAME20};
		return {{(NCO_W-21){e[20]}}, e};
	endfunction

	// Bus slave: one wait state, then a single-cycle answer
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0;
		end
		else if (CE)
		begin
			if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST)
			begin
				AVS_WAITREQUEST <= 1'b0;
				case (AVS_ADDRESS)
					REG_CTRL: AVS_READDATA <= ctrl;
					REG_BW: AVS_READDATA <= bwreg;
					REG_CAL: AVS_READDATA <= cal;
					REG_HOLD: AVS_READDATA <= hold_ofs;
					REG_MON: AVS_READDATA <= mon;
					REG_PPRIO: AVS_READDATA <= pprio;
					REG_APRIO: AVS_READDATA <= aprio;
					REG_THR: AVS_READDATA <= thr;
					REG_DIVN: AVS_READDATA <= divn;
					REG_LIM: AVS_READDATA <= lim;
					REG_STATUS: AVS_READDATA <= {7'h0, REF_LOST, aux_state, aux_sel, pri_state, pri_sel,
						act_alarm, hard_flag, soft_flag, valid};
					REG_PHASE: AVS_READDATA <= {12'h0, phase_res};
					REG_PFREQ: AVS_READDATA <= pri_freq[NCO_W-1-:32];
					default: AVS_READDATA <= 32'h0;
				endcase
			end
			else
				AVS_WAITREQUEST <= 1'b1;
		end
	end

	// Configuration registers; rate bit taken from the strap during reset
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			ctrl <= CTRL_RST | (32'(RATE_SEL) << C_SONET);
			bwreg <= BW_RST;
			cal <= 32'h0;
			hold_ofs <= 32'h0;
			mon <= MON_RST;
			pprio <= PRIO_RST;
			aprio <= PRIO_RST;
			thr <= THR_RST;
			divn <= DIVN_RST;
			lim <= LIM_RST;
		end
		else if (wr)
		begin
			case (AVS_ADDRESS)
				REG_CTRL: ctrl <= merge(ctrl, AVS_WRITEDATA, AVS_BYTEENABLE);
				REG_BW: bwreg <= merge(bwreg, AVS_WRITEDATA, AVS_BYTEENABLE);
				REG_CAL: cal <= merge(cal, AVS_WRITEDATA, AVS_BYTEENABLE);
				REG_HOLD: hold_ofs <= merge(hold_ofs, AVS_WRITEDATA, AVS_BYTEENABLE);
				REG_MON: mon <= merge(mon, AVS_WRITEDATA, AVS_BYTEENABLE);
				REG_PPRIO: pprio <= merge(pprio, AVS_WRITEDATA, AVS_BYTEENABLE);
				REG_APRIO: aprio <= merge(aprio, AVS_WRITEDATA, AVS_BYTEENABLE);
				REG_THR: thr <= merge(thr, AVS_WRITEDATA, AVS_BYTEENABLE);
				REG_DIVN: divn <= merge(divn, AVS_WRITEDATA, AVS_BYTEENABLE);
				REG_LIM: lim <= merge(lim, AVS_WRITEDATA, AVS_BYTEENABLE);
				default: ;
			endcase
		end
	end

	// Shared leak timebase and edge detect
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			leak_cnt <= 20'h0;
			ref_q <= '0;
			sync_q <= 1'b0;
		end
		else if (CE)
		begin
			leak_cnt <= (leak_cnt == 20'(LEAK_CYCS - 1)) ? 20'h0 : leak_cnt + 20'h1;
			ref_q <= REF_INPUT;
			sync_q <= SYNC_PULSE_INPUT;
		end
	end
	assign leak = leak_cnt == 20'(LEAK_CYCS - 1);
	assign rise = REF_INPUT & ~ref_q;
	assign sync_rise = SYNC_PULSE_INPUT && !sync_q;

	// One monitor per input, running whether or not selected
	for (genvar gi = 0; gi < NREF; gi++)
	begin : g_mon
		wire [1:0] mode = mon[2*gi+:2];
		wire den = divn[D_EN+gi];
		wire [19:0] dev = (since[gi] > FRAME20) ? since[gi] - FRAME20 : FRAME20 - since[gi];
		wire anomaly = !rise[gi] && act_cnt[gi] == 18'(ACT_CYC - 1);
		assign tick[gi] = rise[gi] && (!den || divc[gi] == divn[13:0]);
		assign fast_lost[gi] = per_last[gi] != 20'h0 && since[gi] > {per_last[gi][18:0], 1'b0};
		// Hard limit rejects; soft limit never affects validity
		// A monitored input qualifies only after one measured period, so a dead pin never locks
		assign valid[gi] = (mode == MON_OFF) || (per_last[gi] != 20'h0 && !act_alarm[gi] &&
			!(mode == MON_BOTH && hard_flag[gi]));
		assign ok[gi] = valid[gi] && !fast_lost[gi];

		// Pre-divider, period measurement, frequency limits
		always_ff @(posedge CLK)
		begin
			if (!RSTN)
			begin
				divc[gi] <= 14'h0;
				since[gi] <= 20'h0;
				per_last[gi] <= 20'h0;
				hard_flag[gi] <= 1'b0;
				soft_flag[gi] <= 1'b0;
			end
			else if (CE)
			begin
				if (rise[gi])
					divc[gi] <= (den && divc[gi] != divn[13:0]) ? divc[gi] + 14'h1 : 14'h0;
				since[gi] <= tick[gi] ? 20'h0 : (since[gi] == 20'hfffff ? since[gi] : since[gi] + 20'h1);
				if (tick[gi])
					per_last[gi] <= since[gi];
				// Frequency is judged only while activity is clean
				if (mode != MON_BOTH)
				begin
					hard_flag[gi] <= 1'b0;
					soft_flag[gi] <= 1'b0;
				end
				else if (tick[gi] && !act_alarm[gi])
				begin
					hard_flag[gi] <= dev > {4'h0, lim[31:16]};
					soft_flag[gi] <= dev > {4'h0, lim[15:0]};
				end
			end
		end

		// Activity anomalies fill a leaky bucket against the input's own threshold
		always_ff @(posedge CLK)
		begin
			if (!RSTN)
			begin
				act_cnt[gi] <= 18'h0;
				bucket[gi] <= 8'h0;
				act_alarm[gi] <= 1'b0;
			end
			else if (CE)
			begin
				act_cnt[gi] <= (rise[gi] || anomaly) ? 18'h0 : act_cnt[gi] + 18'h1;
				if (anomaly && bucket[gi] != 8'hff)
					bucket[gi] <= bucket[gi] + 8'h1;
				else if (leak && !anomaly && bucket[gi] != 8'h0)
					bucket[gi] <= bucket[gi] - 8'h1;
				if (mode == MON_OFF)
					act_alarm[gi] <= 1'b0;
				else if (bucket[gi] >= thr[8*gi+:8] && thr[8*gi+:8] != 8'h0)
					act_alarm[gi] <= 1'b1;
				else if (bucket[gi] == 8'h0)
					act_alarm[gi] <= 1'b0;
			end
		end
	end

	// Candidates: host-forced input or best by each path's priorities
	assign pri_cand = pforce ? {ok[ctrl[C_PFSEL+:2]], ctrl[C_PFSEL+:2]} : best_ref(ok, pprio[15:0]);
	assign aux_cand = aforce ? {ok[ctrl[C_AFSEL+:2]], ctrl[C_AFSEL+:2]} : best_ref(ok, aprio[15:0]);

	// Primary path controller: software can override the state
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			pri_state <= PS_FREE;
			pri_sel <= 2'h0;
			REF_LOST <= 1'b0;
		end
		else if (CE)
		begin
			case (pri_force)
				FORCE_FREE: pri_state <= PS_FREE;
				FORCE_HOLD: pri_state <= PS_HOLD;
				FORCE_LOCK:
				begin
					pri_state <= PS_LOCK;
					if (pri_cand[2])
						pri_sel <= pri_cand[1:0];
				end
				default:
				case (pri_state)
					PS_FREE:
					if (pri_cand[2])
					begin
						pri_state <= PS_LOCK;
						pri_sel <= pri_cand[1:0];
					end
					PS_LOCK:
					if (!ok[pri_sel])
					begin
						pri_state <= PS_HOLD;
						REF_LOST <= 1'b1;
					end
					// Non-revertive keeps a healthy reference even if a better one returns
					else if (pri_cand[2] && pri_cand[1:0] != pri_sel && (!nonrev || pforce))
						pri_sel <= pri_cand[1:0];
					PS_HOLD:
					if (pri_cand[2])
					begin
						pri_state <= PS_LOCK;
						pri_sel <= pri_cand[1:0];
						REF_LOST <= 1'b0;
					end
					default: pri_state <= PS_FREE;
				endcase
			endcase
		end
	end

	// Primary frequency word: trimmed free-run, frequency lock, held value
	assign free_word = NOM + {{(NCO_W-32){cal[31]}}, cal};
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			pri_freq <= NOM;
			hold_freq <= NOM;
		end
		else if (CE)
		begin
			case (pri_state)
				PS_LOCK:
				if (tick[pri_sel])
				begin
					pri_freq <= pri_freq - (perr(since[pri_sel]) << (BW_BASE +
						((bwreg[3:0] >= 4'(PRI_BW_STEPS)) ? PRI_BW_STEPS - 1 : int'(bwreg[3:0]))));
					// Filtering trades holdover reaction time for noise immunity
					if (ctrl[C_HFILT])
						hold_freq <= hold_freq + NCO_W'($signed(pri_freq - hold_freq) >>> HOLD_FILT_SH);
					else
						hold_freq <= pri_freq;
				end
				PS_HOLD: pri_freq <= hold_man ? NOM + {{(NCO_W-32){hold_ofs[31]}}, hold_ofs} : hold_freq;
				default: pri_freq <= free_word;
			endcase
		end
	end

	// Primary NCO nominally at 77.76 MHz whatever the pins select
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			{pri_carry, pri_acc} <= '0;
			{aux_acc, PRI_CLK_OUT, AUX_CLK_OUT} <= '0;
		end
		else if (CE)
		begin
			{pri_carry, pri_acc} <= {1'b0, pri_acc} + {1'b0, pri_freq};
			aux_acc <= aux_acc + aux_freq;
			PRI_CLK_OUT <= pri_acc[NCO_W-1];
			AUX_CLK_OUT <= aux_acc[NCO_W-1];
		end
	end

	// 8 kHz and 2 kHz dividers; sync realigns 8 kHz, and 2 kHz only at 2 kHz sync rate
	assign frame_tick = pri_carry && frame_cnt == 14'(NCO_PER_FRAME - 1);
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			frame_cnt <= 14'h0;
			mf_cnt <= 2'h0;
			FRAME_8K_OUT <= 1'b0;
			MFRAME_2K_OUT <= 1'b0;
		end
		else if (CE)
		begin
			FRAME_8K_OUT <= frame_tick && !sync_rise;
			MFRAME_2K_OUT <= frame_tick && !sync_rise && mf_cnt == 2'h3;
			if (sync_rise)
			begin
				frame_cnt <= 14'h0;
				// Faster sync cannot place the 2 kHz phase, so it is left alone
				if (ctrl[C_SYNCR+:2] == SYNC_2K)
					mf_cnt <= 2'h0;
			end
			else if (pri_carry)
			begin
				frame_cnt <= frame_tick ? 14'h0 : frame_cnt + 14'h1;
				if (frame_tick)
					mf_cnt <= mf_cnt + 2'h1;
			end
		end
	end

	// Auxiliary path: fixed controller, source may follow the primary 8 kHz
	assign aux_src_tick = aux_follow ? frame_tick : tick[aux_sel];
	assign aux_src_ok = aux_follow || ok[aux_sel];
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			aux_state <= PS_FREE;
			aux_sel <= 2'h0;
		end
		else if (CE)
		begin
			case (aux_state)
				PS_FREE:
				if (aux_follow || aux_cand[2])
				begin
					aux_state <= PS_LOCK;
					aux_sel <= aux_cand[1:0];
				end
				PS_LOCK:
				if (!aux_src_ok)
					aux_state <= PS_HOLD;
				else if (!aux_follow && aux_cand[2] && aux_cand[1:0] != aux_sel)
					aux_sel <= aux_cand[1:0];
				PS_HOLD:
				if (aux_follow || aux_cand[2])
				begin
					aux_state <= PS_LOCK;
					aux_sel <= aux_cand[1:0];
				end
				default: aux_state <= PS_FREE;
			endcase
		end
	end

	// Auxiliary loop: only three gain settings
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			aux_freq <= NOM;
			aux_since <= 20'h0;
		end
		else if (CE)
		begin
			aux_since <= aux_src_tick ? 20'h0 : (aux_since == 20'hfffff ? aux_since : aux_since + 20'h1);
			if (aux_state == PS_FREE)
				aux_freq <= free_word;
			else if (aux_state == PS_LOCK && aux_src_tick && aux_since != 20'h0)
				aux_freq <= aux_freq - (perr(aux_since) << (AUX_BW_BASE +
					((bwreg[5:4] >= 2'(AUX_BW_STEPS)) ? AUX_BW_STEPS - 1 : int'(bwreg[5:4]))));
		end
	end

	// Phase difference between two chosen inputs, in clock cycles
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			phase_run <= 1'b0;
			phase_cnt <= 20'h0;
			phase_res <= 20'h0;
		end
		else if (CE && ctrl[C_PHEN])
		begin
			if (tick[ctrl[C_PHB+:2]] && phase_run)
			begin
				phase_res <= phase_cnt;
				phase_run <= 1'b0;
			end
			else if (tick[ctrl[C_PHA+:2]])
			begin
				phase_run <= 1'b1;
				phase_cnt <= 20'h0;
			end
			else if (phase_run && phase_cnt != 20'hfffff)
				phase_cnt <= phase_cnt + 20'h1;
		end
	end

	assign PRI_MODE = pri_state;
	assign AUX_MODE = aux_state;

	AST_START_FREE: assert property (@(posedge CLK) disable iff (!RSTN)
		!$past(RSTN) |-> (pri_state == PS_FREE && aux_state == PS_FREE))
		else $error("path not in free-run after reset");
	AST_FREERUN: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && pri_state == PS_FREE) |=> (pri_freq == $past(free_word)))
		else $error("free-run word not oscillator plus trim");
	AST_HOLDOVER: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && pri_state == PS_HOLD && !hold_man) |=> (pri_freq == $past(hold_freq)))
		else $error("holdover word not last good value");
	AST_LOST: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && pri_state == PS_LOCK && pri_force == FORCE_AUTO && fast_lost[pri_sel])
		|=> (pri_state == PS_HOLD && REF_LOST))
		else $error("lost reference did not enter holdover");
	AST_BEST: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && pri_state == PS_HOLD && pri_force == FORCE_AUTO && !pforce && pri_cand[2])
		|=> (pri_state == PS_LOCK && pri_sel == $past(pri_cand[1:0])))
		else $error("holdover did not relock to best input");
	AST_NONREV: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && pri_state == PS_LOCK && nonrev && !pforce && pri_force == FORCE_AUTO && ok[pri_sel])
		|=> (pri_sel == $past(pri_sel)))
		else $error("non-revertive selection switched");
	AST_SYNC: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && sync_rise) |=> (frame_cnt == 14'h0 && !FRAME_8K_OUT))
		else $error("sync did not reset frame divider");
	AST_BUCKET: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && mon[1:0] != MON_OFF && thr[7:0] != 8'h0 && bucket[0] >= thr[7:0]) |=> act_alarm[0] ##0 !valid[0])
		else $error("bucket over threshold without alarm");
	AST_HARD: assert property (@(posedge CLK) disable iff (!RSTN)
		(hard_flag[0] && mon[1:0] == MON_BOTH) |-> !valid[0])
		else $error("hard limit did not reject input");
	AST_FOLLOW: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && aux_follow && aux_state == PS_FREE) |=> (aux_state == PS_LOCK))
		else $error("auxiliary did not lock to primary 8 kHz");
endmodule

//--- inc/drs_pkg.sv
// Constants, register map and types for the reference select block.
// Assumes a 125 MHz system clock driving all monitor and loop logic.
package drs_pkg;
	localparam int NREF            = 4;
	localparam int NCO_W           = 54;
	localparam int CLK_KHZ         = 125000;
	localparam int CLK_PERIOD_PS   = 8000;
	localparam int PRI_OUT_KHZ     = 77760;
	localparam int FRAME_PERIOD_NS = 125000;
	localparam int FRAME_CYC       = FRAME_PERIOD_NS * 1000 / CLK_PERIOD_PS;
	localparam int NCO_PER_FRAME   = PRI_OUT_KHZ / 8;
	localparam int ACT_TIMEOUT_US  = 1000;
	localparam int ACT_TIMEOUT_CYC = ACT_TIMEOUT_US * 1000000 / CLK_PERIOD_PS;
	localparam int LEAK_MS         = 8;
	localparam int LEAK_CYC        = LEAK_MS * 1000000 / (CLK_PERIOD_PS / 1000);
	localparam logic [63:0] NCO_NOM64 = ((64'h1 << NCO_W) / 64'(CLK_KHZ)) * 64'(PRI_OUT_KHZ);
	// Loop gain
	localparam int PRI_BW_STEPS = 10;
	localparam int AUX_BW_STEPS = 3;
	localparam int BW_BASE      = 12;
	localparam int AUX_BW_BASE  = 17;
	localparam int HOLD_FILT_SH = 6;
	// Register byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_BW     = 8'h04;
	localparam logic [7:0] REG_CAL    = 8'h08;
	localparam logic [7:0] REG_HOLD   = 8'h0c;
	localparam logic [7:0] REG_MON    = 8'h10;
	localparam logic [7:0] REG_PPRIO  = 8'h14;
	localparam logic [7:0] REG_APRIO  = 8'h18;
	localparam logic [7:0] REG_THR    = 8'h1c;
	localparam logic [7:0] REG_DIVN   = 8'h20;
	localparam logic [7:0] REG_LIM    = 8'h24;
	localparam logic [7:0] REG_STATUS = 8'h28;
	localparam logic [7:0] REG_PHASE  = 8'h2c;
	localparam logic [7:0] REG_PFREQ  = 8'h30;
	// Control field positions
	localparam int C_PMODE = 0;
	localparam int C_NONREV = 2;
	localparam int C_PFORCE = 3;
	localparam int C_PFSEL = 4;
	localparam int C_AFORCE = 6;
	localparam int C_AFSEL = 7;
	localparam int C_FOLLOW = 9;
	localparam int C_PHEN = 10;
	localparam int C_PHA = 11;
	localparam int C_PHB = 13;
	localparam int C_SONET = 15;
	localparam int C_SYNCR = 16;
	localparam int C_HMAN = 18;
	localparam int C_HFILT = 19;
	localparam int D_EN = 16;
	// Reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] BW_RST    = 32'h0000_0014;
	localparam logic [31:0] MON_RST   = 32'h0000_00aa;
	localparam logic [31:0] PRIO_RST  = 32'h0000_5432;
	localparam logic [31:0] THR_RST   = 32'h0808_0808;
	localparam logic [31:0] DIVN_RST  = 32'h0000_0000;
	localparam logic [31:0] LIM_RST   = 32'h0040_0010;
	// Encodings
	localparam logic [1:0] MON_OFF = 2'h0;
	localparam logic [1:0] MON_ACT = 2'h1;
	localparam logic [1:0] MON_BOTH = 2'h2;
	localparam logic [1:0] FORCE_AUTO = 2'h0;
	localparam logic [1:0] FORCE_FREE = 2'h1;
	localparam logic [1:0] FORCE_LOCK = 2'h2;
	localparam logic [1:0] FORCE_HOLD = 2'h3;
	localparam logic [1:0] SYNC_2K = 2'h0;
	typedef enum logic [1:0] {PS_FREE = 2'b00, PS_LOCK = 2'b01, PS_HOLD = 2'b10} drs_state_t;
endpackage

//--- verification/drs_ref_source.sv
// Model of the reference sources: four 8 kHz clocks with one enable each.
// Assumes the 125 MHz CLK; a disabled input stays low, as a dead line would.
module drs_ref_source
	import drs_pkg::*;
(
	// Clock and enables
	input  wire logic            CLK,
	input  wire logic [NREF-1:0] EN,
	// Reference outputs
	output logic      [NREF-1:0] REF
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;

	// Shared 8 kHz phase; no divide needed, so the default divider setting holds
	always_ff @(posedge CLK)
	begin
		cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
		REF <= EN & {NREF{cnt < FRAME_CYC / 2}};
	end
endmodule

//--- verification/drs_ref_select_bench.sv
// Self-checking bench: register defaults, selection, loss, forcing and sync.
// Assumes drs_ref_source stands in for the reference clocks.
module drs_ref_select_bench
	import drs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, rd, wr, sync, waitreq, lost, f8k, m2k, rate;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, rv;
	logic [1:0]  pmode, amode;
	logic [3:0]  ref_en, refs;
	int          n_errors, checks, i;

	drs_ref_source i_drs_ref_source (.CLK(clk), .EN(ref_en), .REF(refs));
	// Activity timeout just above one 8 kHz period; a short leak keeps the run brief
	drs_ref_select #(.ACT_CYC(20000), .LEAK_CYCS(500)) i_drs_ref_select (
		.CLK(clk), .RSTN(rstn), .CE(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .REF_INPUT(refs), .SYNC_PULSE_INPUT(sync), .RATE_SEL(rate),
		.PRI_CLK_OUT(), .AUX_CLK_OUT(), .FRAME_8K_OUT(f8k), .MFRAME_2K_OUT(m2k), .PRI_MODE(pmode),
		.AUX_MODE(amode), .REF_LOST(lost));

	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		if (seen !== exp)
			n_errors++;
	endtask

	task automatic give_up();
		n_errors++;
		$display("MISMATCH at %0t: wait ran out", $time);
		disable seq;
	endtask

	// One Avalon access; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= ~w;
		addr <= a;
		wdata <= d;
		for (i = 0; i < 20 && waitreq !== 1'b0; i++)
			@(posedge clk);
		if (i == 20)
			give_up();
		rv = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rv, exp);
	endtask

	task automatic t_defaults();
		check({30'h0, pmode}, {30'h0, PS_FREE});
		rd_chk(REG_CTRL, CTRL_RST | (32'h1 << C_SONET));
		rd_chk(REG_BW, BW_RST);
		rd_chk(REG_MON, MON_RST);
		rd_chk(REG_THR, THR_RST);
		rd_chk(REG_LIM, LIM_RST);
		bus(1'b1, 8'h3c, 32'hffff_ffff);
		rd_chk(8'h3c, 32'h0);
		$display("Defaults test done");
	endtask

	task automatic t_config();
		bus(1'b1, REG_BW, 32'h3f);
		rd_chk(REG_BW, 32'h3f);
		bus(1'b1, REG_PPRIO, 32'h1);
		rd_chk(REG_APRIO, PRIO_RST);
		bus(1'b1, REG_PPRIO, PRIO_RST);
		$display("Config test done");
	endtask

	task automatic t_lock();
		ref_en <= 4'h1;
		for (i = 0; i < 60000 && pmode !== PS_LOCK; i++)
			@(posedge clk);
		if (i == 60000)
			give_up();
		check({30'h0, pmode}, {30'h0, PS_LOCK});
		check({30'h0, amode}, {30'h0, PS_LOCK});
		check({31'h0, lost}, 32'h0);
		bus(1'b0, REG_STATUS, 32'h0);
		check({15'h0, rv[24:8]}, {15'h0, 1'b0, PS_LOCK, 2'h0, PS_LOCK, 2'h0, 8'h00});
		check({28'h0, rv[3:0]}, 32'h1);
		check({28'h0, rv[19:16]}, {28'h0, PS_LOCK, 2'h0});
		$display("Lock test done");
	endtask

	task automatic t_loss();
		ref_en <= 4'h0;
		for (i = 0; i < 40000 && lost !== 1'b1; i++)
			@(posedge clk);
		if (i == 40000)
			give_up();
		check({31'h0, lost}, 32'h1);
		check({30'h0, pmode}, {30'h0, PS_HOLD});
		bus(1'b1, REG_CTRL, (32'h1 << C_SONET) | 32'(FORCE_FREE));
		repeat (4) @(posedge clk);
		check({30'h0, pmode}, {30'h0, PS_FREE});
		$display("Loss test done");
	endtask

	// Sync rise restarts the frame divider: next 8k pulse one frame later
	task automatic t_sync();
		sync <= 1'b1;
		@(posedge clk);
		sync <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 16000 && f8k !== 1'b1; i++)
			@(posedge clk);
		if (i == 16000)
			give_up();
		check(32'(i > 15590 && i < 15660), 32'h1);
		check({31'h0, m2k}, 32'h0);
		$display("Sync test done");
	endtask

	// Mid-run reset with the strap low: SDH rate, primary path back in free-run
	task automatic t_strap();
		rate <= 1'b0;
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(REG_CTRL, CTRL_RST);
		check({30'h0, pmode}, {30'h0, PS_FREE});
		check({31'h0, lost}, 32'h0);
		$display("Strap test done");
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		{rstn, rd, wr, sync, addr, wdata, ref_en} = '0;
		rate = 1'b1;
		n_errors = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		begin : seq
			t_defaults();
			t_config();
			t_lock();
			t_loss();
			t_sync();
			t_strap();
		end
		close_out();
	end
endmodule
